// *** src/fsew_dev.sv ***
// Device end: command framing, protection, self-timed wipe and auto-read.
`timescale 1ns/1ps
`default_nettype none
module fsew_dev #(
  parameter int unsigned SECTOR_WIPE_CYC = fsew_pkg::SECTOR_WIPE_CYC,
  parameter int unsigned HALF_BLOCK_WIPE_CYC = fsew_pkg::HALF_BLOCK_WIPE_CYC,
  parameter int unsigned BLOCK_WIPE_CYC = fsew_pkg::BLOCK_WIPE_CYC,
  parameter int unsigned FULL_ARRAY_WIPE_CYC = fsew_pkg::FULL_ARRAY_WIPE_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  fsew_link_if.dev link,
  input wire logic four_wire_cmd_mode_i,
  input wire logic quad_io_enable_i,
  input wire logic [7:0] upper_addr_byte_i,
  input wire logic protect_scheme_selector_i,
  input wire logic [3:0] region_protect_bits_i,
  input wire logic [15:0] persistent_sector_lock_i,
  input wire logic [15:0] dynamic_sector_lock_i,
  input wire logic [15:0] top_sector_lock_i,
  input wire logic [15:0] bottom_sector_lock_i,
  input wire logic boot_enable_i,
  input wire logic [1:0] boot_delay_selector_i,
  input wire logic [27:0] boot_start_i,
  input wire logic [7:0] boot_data_i,
  output logic [31:0] boot_addr_o,
  output logic busy_o,
  output logic unlock_o,
  output logic four_byte_o,
  output logic wipe_start_o,
  output logic wipe_done_o,
  output var fsew_pkg::fsew_wipe_t wipe_kind_o,
  output logic [31:0] wipe_addr_o,
  output logic [17:0] wipe_keep_o
);
  // Frame registers written on the link clock and read here only while
  // select is high and the link clock stands still.
  logic [5:0] ecnt_q;
  logic [7:0] cmd_q;
  logic [31:0] addr_q;

  // System clock side.
  logic cs_s;
  logic cs_d_q;
  logic boot_arm_q;
  logic boot_go_q;
  logic qpi_q;
  logic qe_q;
  logic [1:0] boot_delay_selector_q;
  logic [27:0] bstart_q;
  fsew_pkg::fsew_dstate_t state_q;
  logic [31:0] timer_q;

  fsew_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i(link.cs_n),
    .q_o(cs_s)
  );

  wire frame_end = cs_s & ~cs_d_q;
  wire link_idle = cs_s & cs_d_q;
  wire [5:0] upb = qpi_q ? fsew_pkg::UNITS_BYTE_QUAD : fsew_pkg::UNITS_BYTE_SINGLE; // [RL15]
  wire [5:0] addr_units = four_byte_o ? 6'(upb * 6'h05) : 6'(upb * 6'h04);
  wire op_ok = ecnt_q == upb; // [RL12]
  wire addr_ok = ecnt_q == addr_units; // [RL11]
  wire [31:0] full_addr = four_byte_o ? addr_q : {upper_addr_byte_i, addr_q[23:0]}; // [RL14]

  wire is_sector = cmd_q == fsew_pkg::OP_SECTOR;
  wire is_half = cmd_q == fsew_pkg::OP_HALF;
  wire is_block = cmd_q == fsew_pkg::OP_BLOCK;
  wire is_full = (cmd_q == fsew_pkg::OP_FULL) | (cmd_q == fsew_pkg::OP_FULL_ALT);
  wire addr_wipe = (is_sector | is_half | is_block) & addr_ok;
  wire full_wipe = is_full & op_ok;

  // Protection lookup for the addressed region.
  wire [8:0] blk = full_addr[24:16];
  wire [3:0] region = full_addr[24:21];
  wire [3:0] sec = full_addr[15:12];
  wire [3:0] bp = region_protect_bits_i;
  wire [9:0] bp_blocks = (bp == 4'h0) ? 10'h000 :
                         (bp >= 4'hA) ? 10'h200 : (10'h001 << (bp - 4'h1));
  wire bp_hit = ({2'b00, blk} + {1'b0, bp_blocks}) >= fsew_pkg::BLOCK_COUNT;
  wire [15:0] span = is_sector ? (16'h0001 << sec) : // [RL8]
                     is_half ? (full_addr[15] ? 16'hFF00 : 16'h00FF) : 16'hFFFF; // [RL9]
  wire [15:0] region_lock = persistent_sector_lock_i | dynamic_sector_lock_i;
  wire top_any = |top_sector_lock_i;
  wire bot_any = |bottom_sector_lock_i;
  wire lock_hit = region_lock[region] |
                  ((blk == fsew_pkg::TOP_BLOCK) & |(top_sector_lock_i & span)) |
                  ((blk == 9'h000) & |(bottom_sector_lock_i & span));
  wire prot_hit = protect_scheme_selector_i ? lock_hit : bp_hit; // [RL20]
  wire full_blocked = ~protect_scheme_selector_i & (bp != 4'h0); // [RL21]

  wire cmd_frame = frame_end & ~boot_go_q & (state_q == fsew_pkg::DS_IDLE);
  wire start = cmd_frame & unlock_o & // [RL7]
               ((addr_wipe & ~prot_hit) | (full_wipe & ~full_blocked));
  wire set_unlock = cmd_frame & (cmd_q == fsew_pkg::OP_UNLOCK) & op_ok;
  wire set_four = cmd_frame & (cmd_q == fsew_pkg::OP_FOUR_BYTE) & op_ok;

  fsew_pkg::fsew_wipe_t kind_d;
  wire [31:0] cyc_d = is_sector ? SECTOR_WIPE_CYC : is_half ? HALF_BLOCK_WIPE_CYC :
                      is_block ? BLOCK_WIPE_CYC : FULL_ARRAY_WIPE_CYC;
  assign kind_d = is_sector ? fsew_pkg::WIPE_SECTOR : // [RL5]
                  is_half ? fsew_pkg::WIPE_HALF :
                  is_block ? fsew_pkg::WIPE_BLOCK : fsew_pkg::WIPE_FULL; // [RL10]

  // Configuration seen by the link side changes only between frames.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_d_q <= 1'b1;
      boot_arm_q <= 1'b1;
      boot_go_q <= 1'b0;
      qpi_q <= 1'b0;
      qe_q <= 1'b0;
      boot_delay_selector_q <= 2'h3;
      bstart_q <= 28'hFFFFFFF;
    end else if (ce_i) begin
      cs_d_q <= cs_s;
      if (frame_end) begin
        boot_arm_q <= 1'b0;
      end
      if (link_idle) begin
        boot_go_q <= boot_arm_q & boot_enable_i;
        qpi_q <= four_wire_cmd_mode_i;
        qe_q <= quad_io_enable_i;
        boot_delay_selector_q <= boot_delay_selector_i;
        bstart_q <= boot_start_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= fsew_pkg::DS_IDLE;
      timer_q <= 32'h00000000;
      busy_o <= 1'b0;
      unlock_o <= 1'b0;
      four_byte_o <= 1'b0;
      wipe_start_o <= 1'b0;
      wipe_done_o <= 1'b0;
    end else if (ce_i) begin
      wipe_start_o <= start; // [RL17]
      wipe_done_o <= 1'b0;
      four_byte_o <= four_byte_o | set_four; // [RL14]
      case (state_q)
        fsew_pkg::DS_IDLE: begin
          if (start) begin
            state_q <= fsew_pkg::DS_WIPE;
            busy_o <= 1'b1; // [RL18]
            timer_q <= cyc_d;
          end else if (set_unlock) begin
            unlock_o <= 1'b1;
          end
        end
        fsew_pkg::DS_WIPE: begin
          if (timer_q <= 32'h00000001) begin
            state_q <= fsew_pkg::DS_IDLE;
            busy_o <= 1'b0; // [RL18]
            unlock_o <= 1'b0;
            wipe_done_o <= 1'b1;
          end else begin
            timer_q <= timer_q - 32'h00000001;
          end
        end
        default: state_q <= fsew_pkg::DS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wipe_kind_o <= fsew_pkg::WIPE_NONE;
      wipe_addr_o <= 32'h00000000;
      wipe_keep_o <= 18'h00000;
    end else if (ce_i && start) begin
      wipe_kind_o <= is_full ? fsew_pkg::WIPE_FULL : kind_d;
      wipe_addr_o <= full_addr;
      wipe_keep_o <= (is_full & protect_scheme_selector_i) ? // [RL22]
                     {top_any, bot_any, region_lock} : 18'h00000;
    end
  end

  // Link clock side.
  logic [1:0] st_s;
  logic live_q;
  logic drv_q;
  logic [7:0] osr_q;
  logic [3:0] obits_q;
  logic [3:0] io_q;
  logic [3:0] oe_n_q;

  // The status pair reaches the link side through a synchroniser so
  // that it can be polled while a wipe runs.
  fsew_sync #(.W(2), .INIT(2'b00)) u_st_sync (
    .clk_i(link.sclk),
    .rstn_i(rstn_i),
    .ce_i(1'b1),
    .d_i({unlock_o, busy_o}),
    .q_o(st_s)
  );

  wire frame_rst_n = rstn_i & ~link.cs_n;
  wire [5:0] prev = live_q ? ecnt_q : 6'h00;
  wire [5:0] ecnt_d = (prev == 6'h3F) ? prev : prev + 6'h01;
  wire in_op = prev < upb;
  wire [7:0] cmd_d = ~in_op ? cmd_q :
                     qpi_q ? {cmd_q[3:0], link.io} : {cmd_q[6:0], link.io[0]}; // [RL16]
  wire [31:0] addr_d = in_op ? addr_q :
                       qpi_q ? {addr_q[27:0], link.io} : {addr_q[30:0], link.io[0]};
  wire owide = boot_go_q ? qe_q : qpi_q; // [RL4]
  wire [3:0] ostep = owide ? 4'h4 : 4'h1;
  wire [5:0] bdelay = (boot_delay_selector_q == 2'h3) ? fsew_pkg::BOOT_DELAY_11 : // [RL1]
                      (fsew_pkg::BOOT_DELAY_10 & {6{boot_delay_selector_q == 2'h2}}) | // [RL1]
                      (fsew_pkg::BOOT_DELAY_01 & {6{boot_delay_selector_q == 2'h1}}) | // [RL2]
                      (fsew_pkg::BOOT_DELAY_00 & {6{boot_delay_selector_q == 2'h0}}); // [RL2]
  wire boot_load = boot_go_q & (ecnt_d == bdelay); // [RL3]
  wire stat_load = ~boot_go_q & (cmd_d == fsew_pkg::OP_STATUS) & // [RL19]
                   (ecnt_d == (qpi_q ? upb + 6'h01 : upb)); // Quad needs a turnaround rise.
  wire refill = drv_q & (obits_q == ostep);
  wire [7:0] fill = boot_go_q ? boot_data_i : {6'h00, st_s};
  wire load = boot_load | stat_load | refill;
  wire drv_d = drv_q | boot_load | stat_load;
  wire [7:0] osr_d = load ? fill : (owide ? {osr_q[3:0], 4'h0} : {osr_q[6:0], 1'b0});

  always_ff @(posedge link.sclk or negedge rstn_i) begin
    if (!rstn_i) begin
      ecnt_q <= 6'h00;
      cmd_q <= 8'h00;
      addr_q <= 32'h00000000;
    end else begin
      ecnt_q <= ecnt_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge link.sclk or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_addr_o <= 32'h00000000;
    end else if (boot_go_q & ~live_q) begin
      boot_addr_o <= {bstart_q, 4'h0}; // [RL3]
    end else if (boot_go_q & (boot_load | refill)) begin
      boot_addr_o <= boot_addr_o + 32'h00000001;
    end
  end

  // Everything that drives the pins ends with the frame.
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      live_q <= 1'b0;
      drv_q <= 1'b0;
      osr_q <= 8'h00;
      obits_q <= 4'h0;
      io_q <= 4'h0;
      oe_n_q <= 4'hF;
    end else begin
      live_q <= 1'b1;
      drv_q <= drv_d;
      osr_q <= osr_d;
      obits_q <= load ? 4'h8 : obits_q - ostep;
      io_q <= owide ? osr_d[7:4] : {2'b00, osr_d[7], 1'b0};
      oe_n_q <= ~drv_d ? 4'hF : (owide ? 4'h0 : 4'hD);
    end
  end

  assign link.dev_io = io_q;
  assign link.dev_oe_n = oe_n_q;
endmodule
`default_nettype wire

// *** src/fsew_pkg.sv ***
// Shared constants and types for the serial flash wipe link.
// Notes on behaviour
// RL1: Selector 11 waits 13 cycles, selector 10 waits 11.
// RL2: Selector 01 waits 9 cycles, selector 00 waits 7.
// RL3: Enabled auto-read drives start address data after delay.
// RL4: Auto-read uses one line, four when quad enabled.
// RL5: Sector wipe sets the addressed 4K sector to ones.
// RL6: Host sends write unlock before every wipe.
// RL7: Wipe without unlock latch is ignored entirely.
// RL8: Sector chosen by address bits down to A12.
// RL9: Half-block wipe clears 32K block, bits down to A15.
// RL10: Block wipe clears the 64K block holding address.
// RL11: Addressed wipe rejected unless select rises after address.
// RL12: Full wipe is command only, byte-aligned select rise.
// RL13: Host sends command, three or four address bytes.
// RL14: Three-byte addressing unless four-byte entry or upper byte.
// RL15: Command is 8 single clocks or 2 quad clocks.
// RL16: Single-line mode ignores the upper three lines.
// RL17: Self-timed wipe starts when select rises.
// RL18: Busy reads one during wipe; completion clears busy, unlock.
// RL19: Busy status stays readable during a wipe.
// RL20: Protected regions are never wiped, by selected scheme.
// RL21: Scheme 0 full wipe only when protect bits zero.
// RL22: Scheme 1 full wipe skips locked blocks, edge blocks.
package fsew_pkg;
  localparam logic [7:0] OP_UNLOCK = 8'h06;
  localparam logic [7:0] OP_SECTOR = 8'h20;
  localparam logic [7:0] OP_HALF = 8'h52;
  localparam logic [7:0] OP_BLOCK = 8'hD8;
  localparam logic [7:0] OP_FULL = 8'hC7;
  localparam logic [7:0] OP_FULL_ALT = 8'h60;
  localparam logic [7:0] OP_FOUR_BYTE = 8'hB7;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [5:0] UNITS_BYTE_SINGLE = 6'h08;
  localparam logic [5:0] UNITS_BYTE_QUAD = 6'h02;
  localparam logic [5:0] BOOT_DELAY_00 = 6'h07;
  localparam logic [5:0] BOOT_DELAY_01 = 6'h09;
  localparam logic [5:0] BOOT_DELAY_10 = 6'h0B;
  localparam logic [5:0] BOOT_DELAY_11 = 6'h0D;
  localparam int CLK_MHZ = 50;
  localparam int SECTOR_WIPE_TIME_US = 100;
  localparam int HALF_BLOCK_WIPE_TIME_US = 200;
  localparam int BLOCK_WIPE_TIME_US = 400;
  localparam int FULL_ARRAY_WIPE_TIME_US = 1000;
  localparam int SECTOR_WIPE_CYC = SECTOR_WIPE_TIME_US * CLK_MHZ;
  localparam int HALF_BLOCK_WIPE_CYC = HALF_BLOCK_WIPE_TIME_US * CLK_MHZ;
  localparam int BLOCK_WIPE_CYC = BLOCK_WIPE_TIME_US * CLK_MHZ;
  localparam int FULL_ARRAY_WIPE_CYC = FULL_ARRAY_WIPE_TIME_US * CLK_MHZ;
  localparam logic [8:0] TOP_BLOCK = 9'h1FF;
  localparam logic [10:0] BLOCK_COUNT = 11'h200;
  localparam logic [3:0] HOLD_CYCLES = 4'h8;
  typedef enum logic [2:0] {WIPE_NONE, WIPE_SECTOR, WIPE_HALF, WIPE_BLOCK, WIPE_FULL} fsew_wipe_t;
  typedef enum logic {DS_IDLE, DS_WIPE} fsew_dstate_t;
  typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_SEND, HS_EXTRA, HS_READ, HS_HOLD} fsew_hstate_t;
endpackage

// *** src/fsew_link_if.sv ***
// Link between the flash controller and the flash device.
`timescale 1ns/1ps
`default_nettype none
interface fsew_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_io;
  logic [3:0] host_oe_n;
  logic [3:0] dev_io;
  logic [3:0] dev_oe_n;
  logic [3:0] io;
  // Undriven lines read high, as with a pull-up.
  assign io = (~dev_oe_n & dev_io) | (~host_oe_n & host_io) | (dev_oe_n & host_oe_n);
  modport host (output sclk, output cs_n, output host_io, output host_oe_n, input io);
  modport dev (input sclk, input cs_n, input io, output dev_io, output dev_oe_n);
endinterface
`default_nettype wire

// *** src/fsew_sync.sv ***
// Two-stage level synchroniser.
`timescale 1ns/1ps
`default_nettype none
module fsew_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= INIT;
      q_o <= INIT;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** src/fsew_host.sv ***
// Host end: frames commands, addresses and reads on the link.
`timescale 1ns/1ps
`default_nettype none
module fsew_host (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  fsew_link_if.host link,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [7:0] req_op_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [2:0] req_abytes_i,
  input wire logic [5:0] req_xunits_i,
  input wire logic [3:0] req_rbytes_i,
  input wire logic req_noop_i,
  input wire logic req_quad_i,
  input wire logic req_rquad_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o
);
  fsew_pkg::fsew_hstate_t st_q;
  logic [1:0] ph_q;
  logic [39:0] tx_q;
  logic [5:0] su_q;
  logic [5:0] xu_q;
  logic [6:0] ru_q;
  logic quad_q;
  logic rquad_q;
  logic [7:0] rx_q;
  logic [3:0] rxb_q;
  logic [3:0] hold_q;
  logic sclk_q;
  logic cs_n_q;
  logic [3:0] io_q;
  logic [3:0] oe_n_q;
  logic [3:0] io_s;

  fsew_sync #(.W(4), .INIT(4'hF)) u_io_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i(link.io),
    .q_o(io_s)
  );

  wire accept = (st_q == fsew_pkg::HS_IDLE) & req_valid_i & req_ready_o;
  wire [31:0] addr_al = req_addr_i << {(3'h4 - req_abytes_i), 3'b000}; // [RL13]
  wire [5:0] sbits = {req_abytes_i, 3'b000} + (req_noop_i ? 6'h00 : 6'h08);
  wire [5:0] sunits = req_quad_i ? {2'b00, sbits[5:2]} : sbits; // [RL15]
  wire [6:0] runits = req_rquad_i ? {2'b00, req_rbytes_i, 1'b0} : {req_rbytes_i, 3'b000};
  wire unit_end = ph_q == 2'h3;
  wire [7:0] rx_d = rquad_q ? {rx_q[3:0], io_s} : {rx_q[6:0], io_s[1]};
  wire [3:0] rxb_d = rxb_q + (rquad_q ? 4'h4 : 4'h1);
  fsew_pkg::fsew_hstate_t after_send;
  fsew_pkg::fsew_hstate_t after_extra;
  assign after_extra = (ru_q != 7'h00) ? fsew_pkg::HS_READ : fsew_pkg::HS_HOLD;
  assign after_send = (xu_q != 6'h00) ? fsew_pkg::HS_EXTRA : after_extra;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= fsew_pkg::HS_IDLE;
      ph_q <= 2'h0;
      su_q <= 6'h00;
      xu_q <= 6'h00;
      ru_q <= 7'h00;
      hold_q <= 4'h0;
      req_ready_o <= 1'b1;
      cs_n_q <= 1'b1;
    end else if (ce_i) begin
      ph_q <= (st_q == fsew_pkg::HS_SETUP) ? 2'h0 : ph_q + 2'h1;
      case (st_q)
        fsew_pkg::HS_IDLE: begin
          if (accept) begin
            st_q <= fsew_pkg::HS_SETUP;
            req_ready_o <= 1'b0;
            cs_n_q <= 1'b0;
            su_q <= sunits;
            xu_q <= req_xunits_i;
            ru_q <= runits;
          end
        end
        fsew_pkg::HS_SETUP: st_q <= (su_q != 6'h00) ? fsew_pkg::HS_SEND : after_send;
        fsew_pkg::HS_SEND: begin
          if (unit_end) begin
            su_q <= su_q - 6'h01;
            st_q <= (su_q == 6'h01) ? after_send : st_q;
          end
        end
        fsew_pkg::HS_EXTRA: begin
          if (unit_end) begin
            xu_q <= xu_q - 6'h01;
            st_q <= (xu_q == 6'h01) ? after_extra : st_q;
          end
        end
        fsew_pkg::HS_READ: begin
          if (unit_end) begin
            ru_q <= ru_q - 7'h01;
            st_q <= (ru_q == 7'h01) ? fsew_pkg::HS_HOLD : st_q;
          end
        end
        fsew_pkg::HS_HOLD: begin
          // Select rises on the unit boundary; the gap lets the device settle.
          cs_n_q <= 1'b1; // [RL11] [RL12]
          hold_q <= hold_q + 4'h1;
          if (hold_q == fsew_pkg::HOLD_CYCLES) begin
            hold_q <= 4'h0;
            st_q <= fsew_pkg::HS_IDLE;
            req_ready_o <= 1'b1;
          end
        end
        default: st_q <= fsew_pkg::HS_IDLE;
      endcase
    end
  end

  wire sending = st_q == fsew_pkg::HS_SEND;
  wire active = sending | (st_q == fsew_pkg::HS_EXTRA) | (st_q == fsew_pkg::HS_READ);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_q <= 40'h0000000000;
      quad_q <= 1'b0;
      rquad_q <= 1'b0;
      sclk_q <= 1'b0;
      io_q <= 4'h0;
      oe_n_q <= 4'hF;
    end else if (ce_i) begin
      if (accept) begin
        tx_q <= req_noop_i ? {addr_al, 8'h00} : {req_op_i, addr_al};
        quad_q <= req_quad_i;
        rquad_q <= req_rquad_i;
      end
      sclk_q <= active & ph_q[1];
      if (active & (ph_q == 2'h0)) begin
        io_q <= quad_q ? tx_q[39:36] : {3'b000, tx_q[39]}; // [RL6]
        oe_n_q <= ~sending ? 4'hF : (quad_q ? 4'h0 : 4'hE);
        tx_q <= sending ? (quad_q ? {tx_q[35:0], 4'h0} : {tx_q[38:0], 1'b0}) : tx_q;
      end else if (~active) begin
        oe_n_q <= 4'hF;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_q <= 8'h00;
      rxb_q <= 4'h0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
    end else if (ce_i) begin
      rsp_valid_o <= 1'b0;
      if (accept) begin
        rxb_q <= 4'h0;
      end else if ((st_q == fsew_pkg::HS_READ) & (ph_q == 2'h1)) begin
        rx_q <= rx_d;
        rxb_q <= (rxb_d == 4'h8) ? 4'h0 : rxb_d;
        if (rxb_d == 4'h8) begin
          rsp_valid_o <= 1'b1;
          rsp_data_o <= rx_d;
        end
      end
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.host_io = io_q;
  assign link.host_oe_n = oe_n_q;
endmodule
`default_nettype wire

// *** sim/fsew_asserts.sv ***
// Checker for the wipe link wires and the device's wipe status.
`timescale 1ns/1ps
`default_nettype none
module fsew_asserts #(
  parameter int unsigned WIPE_CYC = 200
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_oe_n,
  input wire logic [3:0] dev_oe_n,
  input wire logic busy_o,
  input wire logic unlock_o,
  input wire logic wipe_start_o,
  input wire logic wipe_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [15:0] busy_len_q;
  logic [15:0] busy_len_d;
  // The bench gives every wipe kind one length, so one exact figure fits all.
  assign busy_len_d = busy_o ? busy_len_q + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_len_q <= 16'h0000;
    end else begin
      busy_len_q <= busy_len_d;
    end
  end
  sclk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("link clock not idle low outside a frame");
  dev_quiet_a: assert property (cs_n [*6] |-> dev_oe_n == 4'hF)
    else $error("device drives the link while deselected");
  no_clash_a: assert property ((~host_oe_n & ~dev_oe_n) == 4'h0)
    else $error("host and device drive one line together");
  start_busy_a: assert property (wipe_start_o |-> ##[0:1] busy_o)
    else $error("busy not raised at wipe start");
  start_free_a: assert property (wipe_start_o |-> !$past(busy_o))
    else $error("wipe started while busy");
  busy_unlock_a: assert property (busy_o |-> unlock_o)
    else $error("busy without unlock latch");
  done_clear_a: assert property (wipe_done_o |-> ##[0:1] (!busy_o && !unlock_o))
    else $error("busy or unlock left set after wipe");
  busy_len_a: assert property ($fell(busy_o) |-> busy_len_q == 16'(WIPE_CYC))
    else $error("busy length differs from wipe time");
  cover property (wipe_start_o);
  cover property (wipe_done_o);
  cover property (!dev_oe_n[1]);
  cover property (dev_oe_n == 4'h0);
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Bench joining host and device ends of the wipe link.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned WCYC = 200;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rv = 1'b0;
  logic [7:0] rop = 8'h00;
  logic [31:0] radr = 32'h0;
  logic [2:0] rab = 3'h0;
  logic [5:0] rxu = 6'h00;
  logic [3:0] rrb = 4'h0;
  logic rnop = 1'b0;
  logic rq = 1'b0;
  logic rrq = 1'b0;
  logic fwc = 1'b0;
  logic qe = 1'b0;
  logic wps = 1'b0;
  logic ben = 1'b1;
  logic got = 1'b0;
  logic [1:0] bsel = 2'h3;
  logic [3:0] bp = 4'h0;
  logic [7:0] upb = 8'h01;
  logic [15:0] pl = 16'h0;
  logic [15:0] dl = 16'h0;
  logic [15:0] tl = 16'h0;
  logic [15:0] bl = 16'h0;
  logic [27:0] bst = 28'h0;
  logic rdy, rsv, busy, unl, fourb, wst, wdn;
  logic [7:0] rsd;
  logic [31:0] baddr, waddr;
  logic [17:0] wkeep;
  fsew_pkg::fsew_wipe_t wkind;
  logic [7:0] rd[$];
  int miscompares = 0;
  int check_count = 0;
  fsew_link_if link();
  fsew_host i_fsew_host (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .link(link),
    .req_valid_i(rv), .req_ready_o(rdy), .req_op_i(rop), .req_addr_i(radr),
    .req_abytes_i(rab), .req_xunits_i(rxu), .req_rbytes_i(rrb), .req_noop_i(rnop),
    .req_quad_i(rq), .req_rquad_i(rrq), .rsp_valid_o(rsv), .rsp_data_o(rsd));
  fsew_dev #(.SECTOR_WIPE_CYC(WCYC), .HALF_BLOCK_WIPE_CYC(WCYC), .BLOCK_WIPE_CYC(WCYC),
    .FULL_ARRAY_WIPE_CYC(WCYC)) i_fsew_dev (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .link(link), .four_wire_cmd_mode_i(fwc), .quad_io_enable_i(qe), .upper_addr_byte_i(upb),
    .protect_scheme_selector_i(wps), .region_protect_bits_i(bp), .persistent_sector_lock_i(pl),
    .dynamic_sector_lock_i(dl), .top_sector_lock_i(tl), .bottom_sector_lock_i(bl),
    .boot_enable_i(ben), .boot_delay_selector_i(bsel), .boot_start_i(bst),
    .boot_data_i(baddr[7:0] ^ 8'hA5), .boot_addr_o(baddr), .busy_o(busy), .unlock_o(unl),
    .four_byte_o(fourb), .wipe_start_o(wst), .wipe_done_o(wdn), .wipe_kind_o(wkind),
    .wipe_addr_o(waddr), .wipe_keep_o(wkeep));
  fsew_asserts #(.WIPE_CYC(WCYC)) i_fsew_asserts (.clk_i(clk_i), .rstn_i(rstn_i),
    .sclk(link.sclk), .cs_n(link.cs_n), .host_oe_n(link.host_oe_n), .dev_oe_n(link.dev_oe_n),
    .busy_o(busy), .unlock_o(unl), .wipe_start_o(wst), .wipe_done_o(wdn));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (wst === 1'b1) got <= 1'b1;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic reset_dut();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask
  // One whole frame; ready falls at the accepting edge and returns after the hold.
  task automatic xfer(input logic [7:0] op, input logic [31:0] a, input logic [2:0] ab,
      input logic [5:0] xu, input logic [3:0] rb, input logic nop, input logic q);
    int n;
    rd.delete();
    @(posedge clk_i);
    rv <= 1'b1;
    rop <= op;
    radr <= a;
    rab <= ab;
    rxu <= xu;
    rrb <= rb;
    rnop <= nop;
    rq <= q;
    rrq <= q;
    @(posedge clk_i);
    rv <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      if (rsv === 1'b1) rd.push_back(rsd);
      n++;
    end while (rdy !== 1'b1 && n < 3000);
    if (rdy !== 1'b1) begin
      chk("host ready", 32'h1, {31'h0, rdy});
      results();
    end
  endtask
  task automatic wipe(input logic [7:0] op, input logic [31:0] a, input logic [2:0] ab,
      input logic un, input logic go, input logic [2:0] kind);
    int n;
    if (un) xfer(fsew_pkg::OP_UNLOCK, 32'h0, 3'h0, 6'h00, 4'h0, 1'b0, fwc);
    got <= 1'b0;
    xfer(op, a, ab, 6'h00, 4'h0, 1'b0, fwc);
    repeat (4) @(posedge clk_i);
    chk("wipe started", {31'h0, go}, {31'h0, got});
    if (go) begin
      chk("wipe kind", {29'h0, kind}, {29'h0, wkind});
      if (ab != 3'h0) chk("wipe addr", (ab == 3'h3) ? {upb, a[23:0]} : a, waddr);
      xfer(fsew_pkg::OP_STATUS, 32'h0, 3'h0, {5'h00, fwc}, 4'h1, 1'b0, fwc);
      chk("status in wipe", 32'h3, {24'h0, rd[0]});
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
        @(posedge clk_i);
        n++;
      end
      chk("busy and unlock after", 32'h0, {30'h0, busy, unl});
      if (busy !== 1'b0) results();
    end
  endtask
  task automatic t_boot();
    logic [5:0] dly[4];
    logic [31:0] base;
    dly = '{fsew_pkg::BOOT_DELAY_00, fsew_pkg::BOOT_DELAY_01, fsew_pkg::BOOT_DELAY_10,
      fsew_pkg::BOOT_DELAY_11};
    for (int s = 0; s < 4; s++) begin
      bsel <= 2'(s);
      qe <= s[0];
      bst <= 28'h0123450 + 28'(s);
      reset_dut();
      xfer(8'h00, 32'h0, 3'h0, dly[s], 4'h2, 1'b1, s[0]);
      base = {bst, 4'h0};
      chk("boot byte 0", {24'h0, base[7:0] ^ 8'hA5}, {24'h0, rd[0]});
      chk("boot byte 1", {24'h0, (base[7:0] + 8'h01) ^ 8'hA5}, {24'h0, rd[1]});
    end
    ben <= 1'b0;
    reset_dut();
    $display("test auto-read done");
  endtask
  task automatic t_wipes();
    wipe(fsew_pkg::OP_SECTOR, 32'h0012_3456, 3'h3, 1'b1, 1'b1, 3'h1);
    wipe(fsew_pkg::OP_SECTOR, 32'h0012_3456, 3'h3, 1'b0, 1'b0, 3'h0);
    wipe(fsew_pkg::OP_SECTOR, 32'h0012_3456, 3'h2, 1'b1, 1'b0, 3'h0);
    wipe(fsew_pkg::OP_FULL, 32'h0000_0012, 3'h1, 1'b1, 1'b0, 3'h0);
    fwc <= 1'b1;
    @(posedge clk_i);
    wipe(fsew_pkg::OP_HALF, 32'h0012_8000, 3'h3, 1'b1, 1'b1, 3'h2);
    fwc <= 1'b0;
    @(posedge clk_i);
    $display("test framing done");
  endtask
  task automatic t_protect();
    bp <= 4'h1;
    wipe(fsew_pkg::OP_BLOCK, 32'h00FF_0000, 3'h3, 1'b1, 1'b0, 3'h0);
    wipe(fsew_pkg::OP_FULL, 32'h0, 3'h0, 1'b1, 1'b0, 3'h0);
    bp <= 4'h0;
    wipe(fsew_pkg::OP_BLOCK, 32'h00FF_0000, 3'h3, 1'b1, 1'b1, 3'h3);
    wipe(fsew_pkg::OP_FULL_ALT, 32'h0, 3'h0, 1'b1, 1'b1, 3'h4);
    wps <= 1'b1;
    pl <= 16'h0100;
    dl <= 16'h8000;
    tl <= 16'h0010;
    bl <= 16'h0001;
    wipe(fsew_pkg::OP_SECTOR, 32'h0000_1000, 3'h3, 1'b1, 1'b0, 3'h0);
    wipe(fsew_pkg::OP_FULL, 32'h0, 3'h0, 1'b1, 1'b1, 3'h4);
    chk("keep mask", 32'h0003_8100, {14'h0, wkeep});
    wps <= 1'b0;
    $display("test protection done");
  endtask
  task automatic t_four();
    chk("four-byte at reset", 32'h0, {31'h0, fourb});
    xfer(fsew_pkg::OP_FOUR_BYTE, 32'h0, 3'h0, 6'h00, 4'h0, 1'b0, 1'b0);
    chk("four-byte entered", 32'h1, {31'h0, fourb});
    wipe(fsew_pkg::OP_SECTOR, 32'hAB00_1000, 3'h4, 1'b1, 1'b1, 3'h1);
    $display("test four-byte done");
  endtask
  initial begin
    t_boot();
    t_wipes();
    t_protect();
    t_four();
    results();
  end
endmodule
`default_nettype wire
